// ==== inc/tsp_pkg.sv ====
// Shared constants and state types of the tone signalling host port.
package tsp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_NS         = 1000000;
  localparam int TICK_CYCLES_DEF = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W          = 20;

  // ---------------------------------------------------------------
  // Serial command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_CTRL      = 8'h01;
  localparam logic [7:0] CMD_TONE1     = 8'h02;
  localparam logic [7:0] CMD_TONE2     = 8'h03;
  localparam logic [7:0] CMD_GPT       = 8'h04;
  localparam logic [7:0] CMD_TONE_ABSENT_INDICATION    = 8'h05;
  localparam logic [7:0] CMD_RD_STATUS = 8'h06;
  localparam logic [7:0] CMD_RD_RXWORD = 8'h07;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_PS_TONE1 = 0;
  localparam int CTRL_PS_TONE2 = 1;
  localparam int CTRL_PS_RX    = 2;
  localparam int CTRL_PS_GPT   = 3;
  localparam int CTRL_SUM_SW   = 4;
  localparam int CTRL_DIS_GPT  = 5;
  localparam int CTRL_DIS_RX   = 6;
  localparam int CTRL_AUDIO_SW = 7;
  localparam logic [7:0] CTRL_RESET = 8'h0f;

  localparam int ST_GPT    = 0;
  localparam int ST_TONE_ABSENT_INDICATION = 1;
  localparam int ST_MEAS   = 2;
  localparam int ST_LOGIC  = 3;

  localparam int TG_HALF_W  = 14;
  localparam int TG_AUX_BIT = 14;
  localparam int RX_W       = 16;
  localparam int BYTE_BITS  = 8;

  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] cs_n_s;
    logic [1:0] din_s;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       first;
    logic [7:0] tx_reg;
    logic       tx_en;
  } tsp_sp_t;

  typedef struct packed {
    logic [TG_HALF_W-1:0] cnt;
    logic                 lvl;
  } tsp_tg_t;

  typedef struct packed {
    logic [7:0]        ctrl;
    logic [15:0]       tone1;
    logic [15:0]       tone2;
    logic [7:0]        gpt_period;
    logic [7:0]        nt_period;
    logic [7:0]        cmd;
    logic [1:0]        byte_idx;
    logic [7:0]        hold;
    logic [2:0]        flags;
    logic              irq_act;
    logic [TICK_W-1:0] tick_cnt;
    logic [7:0]        gpt_cnt;
    logic [7:0]        nt_cnt;
    logic              nt_ind;
    logic [2:0]        rx_s;
    logic [1:0]        logic_s;
    logic [RX_W-1:0]   per_cnt;
    logic [RX_W-1:0]   rx_word;
    logic              aux;
  } tsp_core_t;

endpackage

// ==== logic/tsp_tone_gen.sv ====
// Square wave tone generator with its own power-save input.
`timescale 1ns/100ps
module tsp_tone_gen
  import tsp_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [TG_HALF_W-1:0] half_i,
  input  wire logic                 ps_i,
  output logic                      tone_o
);

  tsp_tg_t st;
  tsp_tg_t next_st;

  // A half period of zero means no tone; power-save holds the output low.
  always_comb
  begin
    next_st = st;
    if (ps_i || half_i == '0)
    begin
      next_st = '0;
    end
    else if (st.cnt >= half_i - 14'h0001)
    begin
      next_st.cnt = '0;
      next_st.lvl = ~st.lvl;
    end
    else
    begin
      next_st.cnt = st.cnt + 14'h0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign tone_o = st.lvl;

  a_ps_silent : assert property (@(posedge clk_i) disable iff (rst_i)
    ps_i |=> !tone_o) else $error("tone active during power-save");

endmodule

// ==== logic/tsp_serial_port.sv ====
// Chip-select framed serial slave: byte receive and tri-state byte reply.
`timescale 1ns/100ps
module tsp_serial_port
  import tsp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       cmd_data_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_load_i,
  output logic            reply_data_o,
  output logic            reply_oe_o,
  output logic [7:0]      rx_byte_o,
  output logic            rx_valid_o,
  output logic            rx_first_o
);

  tsp_sp_t st;
  tsp_sp_t next_st;
  logic    active;
  logic    rise;
  logic    fall;

  always_comb
  begin
    next_st = st;
    next_st.rx_valid = 1'b0;
    next_st.sclk_s = {st.sclk_s[1:0], sclk_i};
    next_st.cs_n_s = {st.cs_n_s[0], cs_n_i};
    next_st.din_s  = {st.din_s[0], cmd_data_i};
    active = !st.cs_n_s[1];
    rise   = st.sclk_s[1] & ~st.sclk_s[2];
    fall   = ~st.sclk_s[1] & st.sclk_s[2];
    if (!active)
    begin
      next_st.bit_cnt = '0;
      next_st.first   = 1'b1;
      next_st.tx_en   = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        next_st.shreg   = {st.shreg[6:0], st.din_s[1]};
        next_st.bit_cnt = st.bit_cnt + 3'h1;
        if (st.bit_cnt == 3'h7)
        begin
          next_st.rx_byte  = {st.shreg[6:0], st.din_s[1]};
          next_st.rx_valid = 1'b1;
        end
      end
      if (st.rx_valid)
      begin
        next_st.first  = 1'b0;
        next_st.tx_en  = tx_load_i;
        next_st.tx_reg = tx_byte_i;
      end
      else if (fall && st.tx_en && st.bit_cnt != '0)
      begin
        next_st.tx_reg = {st.tx_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.cs_n_s <= 2'h3;
      st.first <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign reply_data_o = st.tx_reg[7];
  assign reply_oe_o   = st.tx_en & active;
  assign rx_byte_o    = st.rx_byte;
  assign rx_valid_o   = st.rx_valid;
  assign rx_first_o   = st.first;

  a_reply_hiz_idle : assert property (@(posedge clk_i) disable iff (rst_i)
    st.cs_n_s[1] |-> !reply_oe_o) else $error("reply driven outside a frame");
  a_abort_clears : assert property (@(posedge clk_i) disable iff (rst_i)
    st.cs_n_s[1] |=> st.bit_cnt == '0 && !rx_valid_o) else $error("abort left a partial byte");
  a_byte_on_eighth : assert property (@(posedge clk_i) disable iff (rst_i)
    rx_valid_o |-> $past(st.bit_cnt) == 3'h7 && st.bit_cnt == '0)
    else $error("byte completed at wrong bit count");

endmodule

// ==== logic/tsp_host_port.sv ====
// Tone signalling host port: command decode, timers, tone measurement and interrupt.
//
// Behaviour
// - Command bytes arrive as eight bits, most significant first, on serial clock.
// - Reply bytes shift out with the serial clock only while chip select is held.
// - Reply output is released whenever no reply bits are being returned.
// - Chip select frames each transfer; early release aborts the sequence.
// - A pending interrupt pulls the request line low, otherwise it is released.
// - Request line is open drain so up to eight devices may share it.
// - Timer expiry, no-tone expiry and measurement done raise status flags.
// - Each interrupt source is silent while its function is in power-save.
// - Control bits 5 and 6 keep their sources off the request line.
// - Status shows the live level of the general purpose logic input.
// - Control bit 7 opens or closes the standalone audio switch.
// - Each tone generator has its own power-save control.
// - No-tone indication follows once the programmed no-tone period has elapsed.
// - Each received tone is measured and readable as a received data word.
// - A programmable timer marks transmit periods and flags each expiry.
// - Bit 14 of tone generator two selects the auxiliary output mode.
// - Control bit 4 drives the switch onto the transmit modulation path.
`timescale 1ns/100ps
module tsp_host_port
  import tsp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic cmd_data_i,
  output logic      reply_data_o,
  output logic      reply_oe_o,
  output logic      irq_n_o,
  output logic      irq_oe_o,
  input  wire logic logic_i,
  input  wire logic rx_tone_i,
  output logic      tone1_o,
  output logic      tone2_o,
  output logic      aux_tone_o,
  output logic      aux_is_beep_o,
  output logic      sum_switch_o,
  output logic      audio_switch_o,
  output logic      tone_absent_indication_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  tsp_core_t  st;
  tsp_core_t  next_st;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       rx_first;
  logic [7:0] tx_byte;
  logic       tx_load;
  logic [2:0] clr;
  logic [2:0] en;
  logic       tick;
  logic       gpt_evt;
  logic       nt_evt;
  logic       meas_evt;
  logic       rx_rise;
  logic [7:0] status_now;

  // ---------------------------------------------------------------
  // Serial port and tone generators
  // ---------------------------------------------------------------
  tsp_serial_port u_port (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .sclk_i       (sclk_i),
    .cs_n_i       (cs_n_i),
    .cmd_data_i   (cmd_data_i),
    .tx_byte_i    (tx_byte),
    .tx_load_i    (tx_load),
    .reply_data_o (reply_data_o),
    .reply_oe_o   (reply_oe_o),
    .rx_byte_o    (rx_byte),
    .rx_valid_o   (rx_valid),
    .rx_first_o   (rx_first)
  );

  tsp_tone_gen u_tone1 (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .half_i (st.tone1[TG_HALF_W-1:0]),
    .ps_i   (st.ctrl[CTRL_PS_TONE1]),
    .tone_o (tone1_o)
  );

  tsp_tone_gen u_tone2 (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .half_i (st.tone2[TG_HALF_W-1:0]),
    .ps_i   (st.ctrl[CTRL_PS_TONE2]),
    .tone_o (tone2_o)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st  = st;
    tx_byte  = '0;
    tx_load  = 1'b0;
    clr      = '0;
    gpt_evt  = 1'b0;
    nt_evt   = 1'b0;
    meas_evt = 1'b0;
    en = {~st.ctrl[CTRL_DIS_RX], ~st.ctrl[CTRL_DIS_RX], ~st.ctrl[CTRL_DIS_GPT]};
    status_now = {4'h0, st.logic_s[1], st.flags};

    // Input synchronisers; the first stage feeds only the second.
    next_st.rx_s    = {st.rx_s[1:0], rx_tone_i};
    next_st.logic_s = {st.logic_s[0], logic_i};
    rx_rise = st.rx_s[1] & ~st.rx_s[2];

    // Timer base tick.
    tick = (st.tick_cnt == TICK_W'(TICK_CYCLES - 1));
    next_st.tick_cnt = tick ? '0 : st.tick_cnt + TICK_W'(1);

    // Command decode: first byte of a frame is the command.
    if (rx_valid)
    begin
      if (rx_first)
      begin
        next_st.cmd      = rx_byte;
        next_st.byte_idx = '0;
        if (rx_byte == CMD_RD_STATUS)
        begin
          tx_load = 1'b1;
          tx_byte = status_now;
          clr     = st.flags;
        end
        else if (rx_byte == CMD_RD_RXWORD)
        begin
          tx_load = 1'b1;
          tx_byte = st.rx_word[15:8];
        end
      end
      else
      begin
        if (st.byte_idx != 2'h3)
          next_st.byte_idx = st.byte_idx + 2'h1;
        case (st.cmd)
          CMD_CTRL:
            if (st.byte_idx == '0)
              next_st.ctrl = rx_byte;
          CMD_TONE1, CMD_TONE2:
            if (st.byte_idx == '0)
              next_st.hold = rx_byte;
            else if (st.byte_idx == 2'h1)
            begin
              if (st.cmd == CMD_TONE1)
                next_st.tone1 = {st.hold, rx_byte};
              else
                next_st.tone2 = {st.hold, rx_byte};
            end
          CMD_GPT:
            if (st.byte_idx == '0)
            begin
              next_st.gpt_period = rx_byte;
              next_st.gpt_cnt    = rx_byte;
            end
          CMD_TONE_ABSENT_INDICATION:
            if (st.byte_idx == '0)
            begin
              next_st.nt_period = rx_byte;
              next_st.nt_cnt    = rx_byte;
            end
          CMD_RD_RXWORD:
            if (st.byte_idx == '0)
            begin
              tx_load = 1'b1;
              tx_byte = st.rx_word[7:0];
            end
          default:
            next_st.hold = st.hold;
        endcase
      end
    end

    // General purpose period timer.
    if (st.ctrl[CTRL_PS_GPT])
      next_st.gpt_cnt = st.gpt_period;
    else if (tick && st.gpt_period != '0)
    begin
      if (st.gpt_cnt <= 8'h01)
      begin
        next_st.gpt_cnt = st.gpt_period;
        gpt_evt = 1'b1;
      end
      else
        next_st.gpt_cnt = st.gpt_cnt - 8'h01;
    end

    // Tone period measurement and no-tone timer.
    if (st.ctrl[CTRL_PS_RX])
    begin
      next_st.per_cnt = '0;
      next_st.nt_cnt  = st.nt_period;
    end
    else
    begin
      if (st.per_cnt != '1)
        next_st.per_cnt = st.per_cnt + RX_W'(1);
      if (rx_rise)
      begin
        // The cycle of the edge itself counts, so the word is the full period.
        next_st.per_cnt = RX_W'(1);
        if (st.per_cnt != '1 && st.per_cnt != '0)
        begin
          next_st.rx_word = st.per_cnt;
          next_st.nt_cnt  = st.nt_period;
          next_st.nt_ind  = 1'b0;
          meas_evt = 1'b1;
        end
      end
      else if (tick && st.nt_cnt != '0)
      begin
        next_st.nt_cnt = st.nt_cnt - 8'h01;
        if (st.nt_cnt == 8'h01)
        begin
          next_st.nt_ind = 1'b1;
          nt_evt = 1'b1;
        end
      end
    end

    // Sticky flags: a new event wins over the acknowledge.
    next_st.flags = (st.flags & ~clr) | {meas_evt, nt_evt, gpt_evt};
    next_st.irq_act = |(next_st.flags & en);

    // Auxiliary output follows generator two and is held low in its power-save.
    next_st.aux = st.ctrl[CTRL_PS_TONE2] ? 1'b0 : tone2_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
    end
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign irq_n_o  = 1'b0;
  assign irq_oe_o = st.irq_act;
  assign aux_tone_o    = st.aux;
  assign aux_is_beep_o = st.tone2[TG_AUX_BIT];
  assign sum_switch_o  = st.ctrl[CTRL_SUM_SW];
  assign audio_switch_o = st.ctrl[CTRL_AUDIO_SW];
  assign tone_absent_indication_o = st.nt_ind;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_ctrl_cmd;
    rx_valid && rx_first && rx_byte == CMD_CTRL;
  endsequence

  sequence s_ctrl_data;
    rx_valid && !rx_first;
  endsequence

  a_ctrl_write_sw : assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctrl_cmd ##[2:300] s_ctrl_data
    |=> audio_switch_o == $past(rx_byte[7]) && sum_switch_o == $past(rx_byte[4]))
    else $error("control byte did not reach the switches");

  a_irq_pending : assert property (@(posedge clk_i) disable iff (rst_i)
    |(st.flags & en) && $stable(st.ctrl) |-> ##[0:1] irq_oe_o)
    else $error("pending interrupt not driven");

  a_irq_released : assert property (@(posedge clk_i) disable iff (rst_i)
    !irq_oe_o && $stable(st.ctrl) |-> (st.flags & en) == '0)
    else $error("request released while a flag stayed pending");

  a_irq_disabled : assert property (@(posedge clk_i) disable iff (rst_i)
    st.ctrl[CTRL_DIS_GPT] && st.ctrl[CTRL_DIS_RX] |=> !irq_oe_o)
    else $error("disabled sources drove the request");

  a_irq_open_drain : assert property (@(posedge clk_i) disable iff (rst_i)
    irq_oe_o |-> irq_n_o == 1'b0) else $error("request driven high");

  a_ps_gpt_quiet : assert property (@(posedge clk_i) disable iff (rst_i)
    st.ctrl[CTRL_PS_GPT] && !st.flags[ST_GPT] && clr == '0 |=> !st.flags[ST_GPT])
    else $error("timer flag set in power-save");

  a_ps_rx_quiet : assert property (@(posedge clk_i) disable iff (rst_i)
    st.ctrl[CTRL_PS_RX] |-> !meas_evt && !nt_evt)
    else $error("receive event in power-save");

  a_status_ack : assert property (@(posedge clk_i) disable iff (rst_i)
    clr != '0 && !gpt_evt && !nt_evt && !meas_evt |=> (st.flags & $past(clr)) == '0)
    else $error("status read did not acknowledge flags");

  a_status_logic : assert property (@(posedge clk_i) disable iff (rst_i)
    tx_load && rx_first |-> (rx_byte != CMD_RD_STATUS) || tx_byte[ST_LOGIC] == st.logic_s[1])
    else $error("status logic bit wrong");

  a_tone_absent_indication_flag : assert property (@(posedge clk_i) disable iff (rst_i)
    nt_evt |=> tone_absent_indication_o && st.flags[ST_TONE_ABSENT_INDICATION])
    else $error("no-tone expiry not indicated");

  a_meas_word : assert property (@(posedge clk_i) disable iff (rst_i)
    meas_evt |=> st.rx_word == $past(st.per_cnt) && st.flags[ST_MEAS])
    else $error("measurement not captured");

  a_gpt_period : assert property (@(posedge clk_i) disable iff (rst_i)
    gpt_evt |=> st.gpt_cnt == $past(st.gpt_period) && st.flags[ST_GPT])
    else $error("timer did not reload on expiry");

endmodule

// ==== bench/tsp_host_model.sv ====
// Serial bus master model of the microcontroller that drives the host port.
`timescale 1ns/100ps
module tsp_host_model
(
  input  wire logic clk_i,
  input  wire logic reply_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      cmd_data_o
);
  // ---------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------
  initial
  begin
    sclk_o     = 1'b0;
    cs_n_o     = 1'b1;
    cmd_data_o = 1'b0;
  end

  // One serial clock phase: 80 ns, half of the 160 ns link clock.
  task automatic half_phase();
    repeat (8) @(negedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // Framed transfer; a bit count below a whole byte aborts the frame.
  // ---------------------------------------------------------------
  task automatic xfer(input int nbits, input logic [23:0] tx, output logic [15:0] rx);
    int i;
    rx     = 16'h0000;
    cs_n_o = 1'b0;
    half_phase();
    for (i = nbits - 1; i >= 0; i--)
    begin
      cmd_data_o = tx[i];
      half_phase();
      sclk_o = 1'b1;
      rx     = {rx[14:0], reply_i};
      half_phase();
      sclk_o = 1'b0;
    end
    half_phase();
    cs_n_o     = 1'b1;
    // A released data line does not keep its last level.
    cmd_data_o = ~cmd_data_o;
    half_phase();
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking testbench of the tone signalling host port.
`timescale 1ns/100ps
module testbench;
  import tsp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        logic_in = 1'b0;
  logic        rx_tone = 1'b0;
  logic        rx_run = 1'b0;
  logic        sclk, cs_n, cmd_data, reply_data, reply_oe, irq_n, irq_oe;
  logic        tone1, tone2, aux_tone, aux_beep, sum_sw, audio_sw, tone_abs;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  string       nm_q[$];
  logic [15:0] ex_q[$];
  logic [15:0] got;
  event        got_ev;
  wire         reply_pin = reply_oe ? reply_data : 1'bz;
  wire         irq_pin = irq_oe ? irq_n : 1'b1;

  always #5 clk = ~clk;

  tsp_host_port #(.TICK_CYCLES(16)) i_dut (
    .clk_i(clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .cmd_data_i(cmd_data),
    .reply_data_o(reply_data), .reply_oe_o(reply_oe), .irq_n_o(irq_n), .irq_oe_o(irq_oe),
    .logic_i(logic_in), .rx_tone_i(rx_tone), .tone1_o(tone1), .tone2_o(tone2),
    .aux_tone_o(aux_tone), .aux_is_beep_o(aux_beep), .sum_switch_o(sum_sw),
    .audio_switch_o(audio_sw), .tone_absent_indication_o(tone_abs));

  tsp_host_model i_host (.clk_i(clk), .reply_i(reply_pin), .sclk_o(sclk), .cs_n_o(cs_n),
    .cmd_data_o(cmd_data));

  // ---------------------------------------------------------------
  // Received tone source: period of 40 clock cycles while running.
  // ---------------------------------------------------------------
  always
  begin
    repeat (20) @(negedge clk);
    if (rx_run)
      rx_tone <= ~rx_tone;
  end

  // ---------------------------------------------------------------
  // Result watcher and closing report
  // ---------------------------------------------------------------
  always @(got_ev)
  begin
    comparisons++;
    if (got !== ex_q[0])
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm_q[0], ex_q[0], got);
    end
    void'(ex_q.pop_front());
    void'(nm_q.pop_front());
  end

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      errors = errors + 1;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nm_q.push_back(nm);
    ex_q.push_back(e);
    got = g;
    -> got_ev;
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] v, input int nb);
    logic [15:0] r;
    i_host.xfer(8 + 8 * nb, (nb == 2) ? {c, v} : {8'h00, c, v[7:0]}, r);
    repeat (4) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] c, input int nb, output logic [15:0] r);
    logic [15:0] x;
    i_host.xfer(8 + 8 * nb, (nb == 2) ? {c, 16'h0000} : {8'h00, c, 8'h00}, x);
    r = (nb == 2) ? x : {8'h00, x[7:0]};
    chk("reply released", 16'h0000, {15'h0, reply_oe});
  endtask

  task automatic wait_sig(input int which, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      if (((which == 0) ? irq_oe : tone_abs) === 1'b1)
        break;
      @(negedge clk);
    end
  endtask

  task automatic count_edges(output int c1, output int c2);
    logic p1, p2;
    int   i;
    c1 = 0;
    c2 = 0;
    p1 = tone1;
    p2 = tone2;
    for (i = 0; i < 100; i++)
    begin
      @(negedge clk);
      if (tone1 !== p1) c1++;
      if (tone2 !== p2) c2++;
      p1 = tone1;
      p2 = tone2;
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [15:0] r;
    logic [7:0]  v;
    int          c1, c2;
    void'($urandom(32'h54b71e6c));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("reset outputs", 16'h0000, {7'h0, reply_oe, irq_oe, tone1, tone2, aux_tone, aux_beep,
        sum_sw, audio_sw, tone_abs});
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($urandom);
      wr(CMD_CTRL, {8'h00, (v & 8'h90) | 8'h6f}, 1);
      logic_in = v[0];
      chk("switches", {14'h0, v[7], v[4]}, {14'h0, audio_sw, sum_sw});
      rd(CMD_RD_STATUS, 1, r);
      chk("status logic", {12'h0, v[0], 3'b000}, r);
    end
    i_host.xfer(5, 24'h00001f, r);
    chk("abort released", 16'h0000, {15'h0, reply_oe});
    rd(CMD_RD_STATUS, 1, r);
    chk("status after abort", {12'h0, logic_in, 3'b000}, r);
    logic_in = 1'b0;
    wr(CMD_TONE1, 16'h0005, 2);
    wr(CMD_TONE2, 16'h4007, 2);
    wr(CMD_CTRL, 16'h000e, 1);
    count_edges(c1, c2);
    chk("tone1 running", 16'h0001, {15'h0, c1 >= 18 && c1 <= 22});
    chk("tone2 saved", 16'h0000, 16'(c2));
    chk("aux mode", 16'h0001, {15'h0, aux_beep});
    wr(CMD_CTRL, 16'h000d, 1);
    count_edges(c1, c2);
    chk("tone1 saved", 16'h0000, 16'(c1));
    chk("tone2 running", 16'h0001, {15'h0, c2 >= 12 && c2 <= 16});
    wr(CMD_CTRL, 16'h000f, 1);
    wr(CMD_GPT, 16'h0001, 1);
    repeat (100) @(negedge clk);
    chk("irq in powersave", 16'h0000, {15'h0, irq_oe});
    rd(CMD_RD_STATUS, 1, r);
    chk("status in powersave", 16'h0000, r);
    wr(CMD_GPT, 16'h0002, 1);
    wr(CMD_CTRL, 16'h0007, 1);
    wait_sig(0, 300);
    chk("timer irq", 16'h0001, {15'h0, irq_oe});
    chk("irq pin low", 16'h0000, {15'h0, irq_pin});
    wr(CMD_GPT, 16'h0000, 1);
    wr(CMD_CTRL, 16'h0027, 1);
    chk("irq disabled", 16'h0000, {15'h0, irq_oe});
    chk("irq pin released", 16'h0001, {15'h0, irq_pin});
    wr(CMD_CTRL, 16'h0007, 1);
    chk("irq held", 16'h0001, {15'h0, irq_oe});
    rd(CMD_RD_STATUS, 1, r);
    chk("status timer", 16'h0001, r);
    chk("irq acknowledged", 16'h0000, {15'h0, irq_oe});
    wr(CMD_TONE_ABSENT_INDICATION, 16'h0004, 1);
    wr(CMD_CTRL, 16'h002b, 1);
    rx_run = 1'b1;
    repeat (300) @(negedge clk);
    rd(CMD_RD_STATUS, 1, r);
    chk("measure flag", 16'h0004, r & 16'h0004);
    rd(CMD_RD_RXWORD, 2, r);
    chk("rx word", 16'd40, r);
    rx_run = 1'b0;
    wait_sig(1, 400);
    chk("tone absent", 16'h0001, {15'h0, tone_abs});
    chk("tone_absent_indication irq", 16'h0001, {15'h0, irq_oe});
    rd(CMD_RD_STATUS, 1, r);
    chk("tone_absent_indication flag", 16'h0002, r & 16'h0002);
    results();
  end
endmodule
